// ### shared/pdp_pkg.sv
// constants shared by the pulse-division pwm block and its bench
package pdp_pkg;

  // ----------------------------------------------------------------------------
  // apb addressing
  // ----------------------------------------------------------------------------
  localparam int          ADDR_W      = 18;
  // register indices as printed; byte address is four times the index
  localparam logic [15:0] CTRL_IDX    = 16'hffd0;
  localparam logic [15:0] UPPER_IDX   = 16'hffd1;
  localparam logic [15:0] LOWER_IDX   = 16'hffd2;
  localparam logic [15:0] STATUS_IDX  = 16'hffd3;
  localparam logic [15:0] CKSTP_IDX   = 16'hfffb;
  localparam logic [17:0] CTRL_ADDR   = {CTRL_IDX, 2'b00};
  localparam logic [17:0] UPPER_ADDR  = {UPPER_IDX, 2'b00};
  localparam logic [17:0] LOWER_ADDR  = {LOWER_IDX, 2'b00};
  localparam logic [17:0] STATUS_ADDR = {STATUS_IDX, 2'b00};
  localparam logic [17:0] CKSTP_ADDR  = {CKSTP_IDX, 2'b00};

  // ----------------------------------------------------------------------------
  // reset values and read-back values
  // ----------------------------------------------------------------------------
  localparam logic [7:0]  CTRL_RST    = 8'hfc;
  localparam logic [7:0]  UPPER_RST   = 8'hc0;
  localparam logic [7:0]  LOWER_RST   = 8'h00;
  localparam logic [7:0]  CKSTP_RST   = 8'hff;
  localparam logic [7:0]  WO_READ     = 8'hff;
  localparam logic [3:0]  CKSTP_RSVD  = 4'hf;

  // ----------------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------------
  localparam int          SEL_LSB     = 0;
  localparam int          STBY_BIT    = 1;
  localparam int          UP_W        = 6;
  localparam int          LO_W        = 8;
  localparam int          DUTY_W      = 14;

  // ----------------------------------------------------------------------------
  // waveform geometry, counted in pulses and modulation steps
  // ----------------------------------------------------------------------------
  localparam logic [5:0]  LAST_PULSE  = 6'h3f;
  localparam logic [7:0]  LAST_STEP   = 8'hff;
  localparam logic [14:0] PULSE_BASE  = 15'h0040;
  localparam logic [14:0] PERIOD_STEP = 15'h4000;

endpackage

// ### verilog/pdp_pwm.sv
// pulse-division 14-bit pwm generator with apb register slave
//
// Notes on behaviour
// - the clock select field gives a pwm input clock of 2, 4, 8 or 16 clk for values 0 to 3.
// - one conversion period lasts 16384, 32768, 65536 or 131072 clk, a step of 1, 2, 4 or 8.
// - reset loads the control register with fc, so the clock select field is 00.
// - control bits 7 to 2 read as one and ignore writes, and the whole register reads as ff.
// - the duty is 14 bits, upper 6 in the upper duty register and lower 8 in the lower one.
// - a write to the upper duty register hands both duty bytes to the generator.
// - the generator takes a handed-over duty only at the start of a conversion period.
// - both duty registers read as all ones.
// - reset loads the duty registers with c000, upper c0 and lower 00.
// - each conversion period is made of exactly 64 pulses.
// - high time per period is (duty + 64) steps, at most 16384, each step half an input clock.
// - clock stop bit 1 low puts the block in standby; the register resets to ff.
`timescale 1ns/10ps

module pdp_pwm (
  input  wire logic                        clk,
  input  wire logic                        nrst,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [pdp_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [31:0]                 pwdata,
  output logic                             pready,
  output logic [31:0]                      prdata,
  output logic                             pslverr,
  output logic                             pwm_out
);
  import pdp_pkg::*;

  // ----------------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------------
  typedef struct packed {
    logic [1:0]        sel;    // input clock select
    logic [UP_W-1:0]   up;     // upper duty register
    logic [LO_W-1:0]   lo;     // lower duty register
    logic [DUTY_W-1:0] xfer;   // duty handed to the generator
    logic              pend;   // handed-over duty not yet in use
    logic [DUTY_W-1:0] act;    // duty in use for this period
    logic [3:0]        ckstp;  // clock stop bits 3..0
    logic [3:0]        pre;    // input clock prescaler
    logic [7:0]        step;   // step within the pulse
    logic [5:0]        pulse;  // pulse within the period
    logic              out;    // waveform pin
    logic              rdy;    // apb ready
    logic [31:0]       rdata;  // apb read data
    logic              err;    // apb slave error
  } pdp_state_t;

  localparam pdp_state_t ST_RST = '{
    sel:   CTRL_RST[1:0],
    up:    UPPER_RST[UP_W-1:0],
    lo:    LOWER_RST,
    xfer:  {UPPER_RST[UP_W-1:0], LOWER_RST},
    pend:  1'b0,
    act:   {UPPER_RST[UP_W-1:0], LOWER_RST},
    ckstp: CKSTP_RST[3:0],
    pre:   4'h0,
    step:  8'h00,
    pulse: 6'h00,
    out:   1'b0,
    rdy:   1'b0,
    rdata: 32'h0000_0000,
    err:   1'b0
  };

  pdp_state_t st_r;
  pdp_state_t st_nxt;

  // ----------------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------------
  // last prescaler count of one input clock period
  function automatic logic [3:0] tclk_last(input logic [1:0] s);
    case (s)
      2'h0:    tclk_last = 4'h1;
      2'h1:    tclk_last = 4'h3;
      2'h2:    tclk_last = 4'h7;
      default: tclk_last = 4'hf;
    endcase
  endfunction

  // bit reversal of the pulse number spreads the remainder evenly
  function automatic logic [5:0] rev6(input logic [5:0] v);
    rev6 = {v[0], v[1], v[2], v[3], v[4], v[5]};
  endfunction

  logic       stby;
  logic       step_en;
  logic       wrap;
  logic       extra;
  logic [8:0] hi_len;
  logic       hi_bit;
  logic       wr_acc;
  logic [3:0] half_mask;

  // standby, step timing and the high/low decision of the current step
  assign stby      = ~st_r.ckstp[STBY_BIT];
  assign half_mask = tclk_last(st_r.sel) >> 1;
  // a step is half an input clock, so both input clock edges advance it
  assign step_en   = ~stby && ((st_r.pre & half_mask) == half_mask);
  assign wrap      = step_en && st_r.step == LAST_STEP && st_r.pulse == LAST_PULSE;
  assign extra     = rev6(st_r.pulse) < st_r.act[5:0];
  // one base step per pulse plus the share of the duty
  assign hi_len    = 9'h001 + {1'b0, st_r.act[13:6]} + {8'h00, extra};
  assign hi_bit    = {1'b0, st_r.step} < hi_len;
  assign wr_acc    = psel && penable && st_r.rdy && pwrite && !st_r.err;

  // ----------------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;

    // input clock prescaler; the >= catches a select lowered mid count
    if (!stby) begin
      if (st_r.pre >= tclk_last(st_r.sel)) begin
        st_nxt.pre = 4'h0;
      end else begin
        st_nxt.pre = st_r.pre + 4'h1;
      end
    end

    // 256 steps per pulse, 64 pulses per period
    if (step_en) begin
      st_nxt.step = st_r.step + 8'h01;
      if (st_r.step == LAST_STEP) begin
        st_nxt.pulse = st_r.pulse + 6'h01;
      end
      st_nxt.out = hi_bit;
    end

    // new duty enters only at the period boundary, so no pulse is cut short
    if (wrap && st_r.pend) begin
      st_nxt.act  = st_r.xfer;
      st_nxt.pend = 1'b0;
    end

    // apb setup: decode and prepare the answer for the access phase
    st_nxt.rdy = psel && !penable;
    if (psel && !penable) begin
      st_nxt.err   = 1'b0;
      st_nxt.rdata = 32'h0000_0000;
      case (paddr)
        CTRL_ADDR:   st_nxt.rdata = {24'h00_0000, WO_READ};
        UPPER_ADDR:  st_nxt.rdata = {24'h00_0000, WO_READ};
        LOWER_ADDR:  st_nxt.rdata = {24'h00_0000, WO_READ};
        CKSTP_ADDR:  st_nxt.rdata = {24'h00_0000, CKSTP_RSVD, st_r.ckstp};
        STATUS_ADDR: st_nxt.rdata = {24'h00_0000, 1'b0, stby, st_r.pulse};
        default:     st_nxt.err   = 1'b1;
      endcase
      if (pwrite) begin
        st_nxt.rdata = 32'h0000_0000;
      end
    end

    // apb access: writes take effect on the completing edge
    if (wr_acc) begin
      case (paddr)
        CTRL_ADDR:  st_nxt.sel = pwdata[SEL_LSB +: 2];
        LOWER_ADDR: st_nxt.lo  = pwdata[LO_W-1:0];
        UPPER_ADDR: begin
          st_nxt.up   = pwdata[UP_W-1:0];
          // relies on the lower byte having been written first
          st_nxt.xfer = {pwdata[UP_W-1:0], st_r.lo};
          st_nxt.pend = 1'b1;                                               // set beats clear
        end
        CKSTP_ADDR: st_nxt.ckstp = pwdata[3:0];
        default:    st_nxt.ckstp = st_r.ckstp;
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_r <= ST_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs come straight from the state register
  assign pready  = st_r.rdy;
  assign prdata  = st_r.rdata;
  assign pslverr = st_r.err;
  assign pwm_out = st_r.out;

  // ----------------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  // high steps seen so far in this period, for the duty check
  logic [14:0] hi_acc_r;
  logic [14:0] hi_exp;
  always_ff @(posedge clk) begin
    if (!nrst) begin
      hi_acc_r <= 15'h0000;
    end else if (wrap) begin
      hi_acc_r <= 15'h0000;
    end else if (step_en && hi_bit) begin
      hi_acc_r <= hi_acc_r + 15'h0001;
    end
  end
  // duty above 16320 saturates: no pulse can be longer than itself
  assign hi_exp = ({1'b0, st_r.act} + PULSE_BASE > PERIOD_STEP) ?
                  PERIOD_STEP : {1'b0, st_r.act} + PULSE_BASE;

  ctrl_reset_a: assert property ($rose(nrst) |-> st_r.sel == 2'h0 && st_r.up == 6'h00)
    else $error("select or duty not at reset value");

  duty_reset_a: assert property ($rose(nrst) |-> st_r.act == 14'h0000 && !st_r.pend)
    else $error("generator duty not cleared by reset");

  ctrl_read_a: assert property (psel && !penable && !pwrite && paddr == CTRL_ADDR
                                |=> pready && prdata == 32'h0000_00ff && !pslverr)
    else $error("control register did not read as all ones");

  duty_read_a: assert property (psel && !penable && !pwrite &&
                                (paddr == UPPER_ADDR || paddr == LOWER_ADDR)
                                |=> pready && prdata == 32'h0000_00ff)
    else $error("duty register did not read as all ones");

  upper_xfer_a: assert property (wr_acc && paddr == UPPER_ADDR
                                 |=> st_r.pend &&
                                     st_r.xfer == {$past(pwdata[5:0]), $past(st_r.lo)})
    else $error("upper write did not hand over both duty bytes");

  duty_sync_a: assert property (st_r.act != $past(st_r.act) |-> $past(wrap))
    else $error("duty changed away from a period boundary");

  clk_div_a: assert property ((step_en && st_r.sel == 2'h3) ##1
                              (st_r.sel == 2'h3 && !stby)[*8]
                              |-> step_en && st_r.step == 8'($past(st_r.step, 8) + 8'h01))
    else $error("step spacing wrong for the slowest clock");

  pulse_step_a: assert property (step_en && st_r.step == LAST_STEP
                                 |=> st_r.step == 8'h00 &&
                                     st_r.pulse == 6'($past(st_r.pulse) + 6'h01))
    else $error("pulse count did not advance after 256 steps");

  high_total_a: assert property (wrap |-> hi_acc_r + {14'h0000, hi_bit} == hi_exp)
    else $error("high time of the period differs from duty plus 64");

  standby_hold_a: assert property (stby && !wr_acc |=> $stable(st_r.step) &&
                                   $stable(st_r.pulse) && $stable(st_r.out) && $stable(st_r.act))
    else $error("generator moved while in standby");

endmodule

// ### verification/pdp_filter_model.sv
// far-side model: low-pass filter load that measures the pwm pin
`timescale 1ns/10ps

module pdp_filter_model (
  input  wire logic clk,
  input  wire logic pwm_in,
  input  wire logic clr,
  output int        high_count,
  output int        rise_count,
  output int        wmin,
  output int        wmax
);
  logic prev;
  logic armed;
  int   run;

  initial begin
    prev = 1'b0;
    armed = 1'b0;
    run = 0;
    high_count = 0;
    rise_count = 0;
    wmin = 1000000;
    wmax = 0;
  end

  // integrate high time and pulse widths; the pulse cut by a clear is skipped
  always @(posedge clk) begin
    if (pwm_in) begin
      high_count <= high_count + 1;
    end
    if (pwm_in && !prev) begin
      rise_count <= rise_count + 1;
      run <= 1;
      armed <= 1'b1;
    end else if (pwm_in) begin
      run <= run + 1;
    end
    if (!pwm_in && prev && armed) begin
      wmin <= (run < wmin) ? run : wmin;
      wmax <= (run > wmax) ? run : wmax;
    end
    if (clr) begin
      wmin <= 1000000;
      wmax <= 0;
      armed <= 1'b0;
    end
    prev <= pwm_in;
  end
endmodule

// ### verification/pdp_pwm_tb.sv
// self-checking bench for the pulse-division pwm block
`timescale 1ns/10ps

module pdp_pwm_tb;
  import pdp_pkg::*;
  logic              clk;
  logic              nrst;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata;
  logic              pready;
  logic [31:0]       prdata;
  logic              pslverr;
  logic              pwm_out;
  logic              clr;
  logic [31:0]       rd;
  logic              er;
  int                high_count, rise_count, wmin, wmax;
  int                bad_count;
  int                compares;

  pdp_pwm dut_u (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .pwm_out(pwm_out));
  // the pin is taken as already routed to the pwm by the port mode register
  pdp_filter_model flt_u (.clk(clk), .pwm_in(pwm_out), .clr(clr), .high_count(high_count),
    .rise_count(rise_count), .wmin(wmin), .wmax(wmax));

  initial clk = 1'b0;
  always #25 clk = ~clk;

  // ---------------------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one apb transfer; pready is registered, so the level read just after an edge is the
  // level that edge sampled; data is taken and the request released at that same edge
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, pready, 1'b1);
    end
  endtask

  task automatic give_verdict;
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------------------
  task automatic t_regs;
    apb(1'b0, CTRL_ADDR, 32'h0);
    chk(rd, 32'h0000_00ff);
    apb(1'b1, CTRL_ADDR, 32'h0000_0000);
    apb(1'b0, CTRL_ADDR, 32'h0);
    chk(rd, 32'h0000_00ff);
    apb(1'b0, UPPER_ADDR, 32'h0);
    chk(rd, 32'h0000_00ff);
    apb(1'b0, LOWER_ADDR, 32'h0);
    chk(rd, 32'h0000_00ff);
    apb(1'b0, CKSTP_ADDR, 32'h0);
    chk(rd, 32'h0000_00ff);
    apb(1'b0, 18'h0_0000, 32'h0);
    chk({31'h0, er}, 32'h0000_0001);
    $display("test regs done");
  endtask

  // reset duty plays 64 pulses of one step each
  task automatic t_base;
    int h0;
    int r0;
    h0 = high_count;
    r0 = rise_count;
    repeat (16384) @(posedge clk);
    chk(32'(high_count - h0), 32'h0000_0040);
    chk(32'(rise_count - r0), 32'h0000_0040);
    $display("test base done");
  endtask

  task automatic t_duty;
    int h0;
    int r0;
    apb(1'b1, LOWER_ADDR, 32'h0000_0034);
    apb(1'b1, UPPER_ADDR, 32'h0000_0012);
    repeat (16384) @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    h0 = high_count;
    r0 = rise_count;
    repeat (16384) @(posedge clk);
    chk(32'(high_count - h0), 32'h0000_1234 + 32'h0000_0040);
    chk(32'(rise_count - r0), 32'h0000_0040);
    // 0x1234 + 64 over 64 pulses: every pulse is 73 or 74 steps, and both occur
    chk(32'(wmin == 73 && wmax == 74), 32'h0000_0001);
    $display("test duty done");
  endtask

  // each select scales the 73 or 74 step pulses by its step length
  task automatic t_sel;
    for (int s = 0; s < 4; s++) begin
      apb(1'b1, CTRL_ADDR, 32'(s));
      repeat (512 << s) @(posedge clk);
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
      repeat (1024 << s) @(posedge clk);
      // wmax above the lower bound also proves that some pulse was measured
      chk(32'(wmin >= (73 << s) && wmax <= (74 << s) && wmax >= (73 << s)), 32'h0000_0001);
    end
    $display("test select done");
  endtask

  task automatic t_stby;
    int   h0;
    int   r0;
    logic lvl;
    // upper clock stop bits are written as zero and must still read as one
    apb(1'b1, CKSTP_ADDR, 32'h0000_000d);
    apb(1'b0, CKSTP_ADDR, 32'h0);
    chk(rd, 32'h0000_00fd);
    apb(1'b0, STATUS_ADDR, 32'h0);
    chk(rd & 32'h0000_ffc0, 32'h0000_0040);
    h0 = high_count;
    r0 = rise_count;
    lvl = pwm_out;
    repeat (2000) @(posedge clk);
    chk(32'(high_count - h0), lvl ? 32'h0000_07d0 : 32'h0000_0000);
    chk(32'(rise_count - r0), 32'h0000_0000);
    apb(1'b1, CKSTP_ADDR, 32'h0000_00ff);
    repeat (4200) @(posedge clk);
    chk(32'(rise_count > r0), 32'h0000_0001);
    $display("test standby done");
  endtask

  // ---------------------------------------------------------------------------
  // main sequence and watchdog
  // ---------------------------------------------------------------------------
  initial begin
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    clr = 1'b0;
    bad_count = 0;
    compares = 0;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    t_regs();
    t_base();
    t_duty();
    t_sel();
    t_stby();
    give_verdict();
  end

  // the run needs about 80000 cycles; a hang is cut at 100000
  initial begin
    #5000000;
    bad_count++;
    give_verdict();
  end
endmodule
